// >>> logic/sar_pkg.sv
`default_nettype none
package sar_pkg;
	// System clock period in ns.
	localparam int CLK_NS = 40;
	localparam int RES_BITS = 16;
	// Old result stays readable this long after a conversion start.
	localparam int READ_WIN_NS = 12000;
	localparam int READ_WIN_CYC = READ_WIN_NS / CLK_NS;
	// Busy low time, typical and longest.
	localparam int BUSY_TYP_NS = 18000;
	localparam int BUSY_MAX_NS = 20000;
	localparam int BUSY_CYC = BUSY_TYP_NS / CLK_NS;
	localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_NS;
	// Internal shift clock period window; half period sits mid-window.
	localparam int INT_PER_MIN_NS = 600;
	localparam int INT_PER_MAX_NS = 850;
	localparam int INT_HALF_CYC =
		(INT_PER_MIN_NS + INT_PER_MAX_NS) / 4 / CLK_NS;
	// Start of conversion to first internal shift clock activity.
	localparam int START_DLY_NS = 270;
	localparam int START_DLY_CYC = (START_DLY_NS + CLK_NS - 1) / CLK_NS;
	// External shift clock least period.
	localparam int EXT_PER_MIN_NS = 35;
	// Convert pulse least width.
	localparam int CONV_PULSE_NS = 40;
	localparam int CONV_PULSE_CYC = (CONV_PULSE_NS + CLK_NS - 1) / CLK_NS;
	// Clamp codes, two's complement.
	localparam logic [15:0] FULL_POS = 16'h7FFF;
	localparam logic [15:0] FULL_NEG = 16'h8000;
	// Bits per word on the cascaded line: result plus one fill bit.
	localparam int WORD_SLOT = RES_BITS + 1;
endpackage
`default_nettype wire

// >>> logic/sar_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
	logic rc_n;
	logic cs_n;
	logic busy_n;
	logic sdo;
	logic sclk_host_o;
	logic sclk_host_oe;
	logic sclk_dev_o;
	logic sclk_dev_oe;
	logic sclk;
	// The shared shift clock wire; an undriven line reads low.
	assign sclk = sclk_dev_oe ? sclk_dev_o :
		(sclk_host_oe ? sclk_host_o : 1'b0);
	modport dev (input rc_n, input cs_n, input sclk, output busy_n,
		output sdo, output sclk_dev_o, output sclk_dev_oe);
	modport host (output rc_n, output cs_n, input sclk, input busy_n,
		input sdo, output sclk_host_o, output sclk_host_oe);
endinterface
`default_nettype wire

// >>> logic/sar_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sar_dev #(
	parameter int IN_W = 18
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Link to the host
	sar_link_if.dev link,
	// Converter side
	input wire logic signed [IN_W-1:0] sample_in,
	input wire logic ext_clk_sel,
	input wire logic cascade_in,
	output logic [sar_pkg::RES_BITS-1:0] last_result,
	output logic conv_busy
);
	localparam int W = sar_pkg::RES_BITS;

	// Refuse settings that the clamp or the 10-bit timer cannot serve.
	if (IN_W < W) begin : g_chk_width
		$error("sar_dev: IN_W must be at least the result width");
	end
	if (sar_pkg::BUSY_CYC > sar_pkg::BUSY_MAX_CYC ||
		sar_pkg::BUSY_CYC < sar_pkg::READ_WIN_CYC ||
		sar_pkg::BUSY_CYC > 1024) begin : g_chk_busy
		$error("sar_dev: busy time outside its window");
	end

	typedef enum logic [1:0] {
		SAR_SH_IDLE = 2'b00,
		SAR_SH_DELAY = 2'b01,
		SAR_SH_LOW = 2'b10,
		SAR_SH_HIGH = 2'b11
	} sar_sh_t;

	// Pins from the host and the cascade pass two flops before use.
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 5'h1B;
			sync2_q <= 5'h1B;
		end else begin
			sync1_q <= {link.rc_n, link.cs_n, link.sclk, cascade_in,
				ext_clk_sel};
			sync2_q <= sync1_q;
		end
	end

	wire rc_n_s = sync2_q[4];
	wire cs_n_s = sync2_q[3];
	wire sclk_s = sync2_q[2];
	wire tag_s = sync2_q[1];
	wire ext_s = sync2_q[0];

	// Edge detection on the synchronised levels.
	logic sclk_prev_q;
	logic start_prev_q;
	logic win_prev_q;
	wire start_lvl = ~rc_n_s & ~cs_n_s;
	wire ext_win = ~cs_n_s & rc_n_s;
	wire ext_fall = sclk_prev_q & ~sclk_s & ext_win & ext_s;
	wire win_open = ext_win & ~win_prev_q & ext_s;
	wire win_close = ~ext_win & win_prev_q & ext_s;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_q <= 1'b0;
			start_prev_q <= 1'b0;
			win_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			start_prev_q <= start_lvl;
			win_prev_q <= ext_win;
		end
	end

	// Clamp the input: never wrap, saturate at the full-scale codes.
	wire signed [IN_W-1:0] lim_pos =
		IN_W'(signed'({1'b0, sar_pkg::FULL_POS[W-2:0]}));
	wire signed [IN_W-1:0] lim_neg = -lim_pos - IN_W'(1);
	wire over = sample_in > lim_pos;
	wire under = sample_in < lim_neg;
	wire [W-1:0] clamped = over ? sar_pkg::FULL_POS :
		(under ? sar_pkg::FULL_NEG : sample_in[W-1:0]);

	// Conversion timer. Busy stays low for the typical time, then the
	// new word replaces the old one; holding the old word until then
	// keeps it readable well past the early read window.
	logic conv_q;
	logic [9:0] conv_cnt_q;
	logic [W-1:0] conv_val_q;
	logic [W-1:0] res_q;
	wire start = start_lvl & ~start_prev_q & ~conv_q;
	wire commit = conv_q && conv_cnt_q == 10'(sar_pkg::BUSY_CYC - 1);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			conv_q <= 1'b0;
			conv_cnt_q <= 10'h000;
			conv_val_q <= 16'h0000;
			res_q <= 16'h0000;
		end else if (start) begin
			conv_q <= 1'b1;
			conv_cnt_q <= 10'h000;
			conv_val_q <= clamped;
		end else if (commit) begin
			conv_q <= 1'b0;
			res_q <= conv_val_q;
		end else if (conv_q) begin
			conv_cnt_q <= conv_cnt_q + 10'h001;
		end
	end

	assign link.busy_n = ~conv_q;
	assign conv_busy = conv_q;
	assign last_result = res_q;

	// Internal shift clock engine: delay, then 16 low/high pulses.
	sar_sh_t sh_q;
	logic [4:0] sh_cnt_q;
	logic [4:0] sh_bit_q;
	wire int_go = start & ~ext_s;
	wire dly_end = sh_cnt_q == 5'(sar_pkg::START_DLY_CYC - 1);
	wire half_end = sh_cnt_q == 5'(sar_pkg::INT_HALF_CYC - 1);
	wire last_bit = sh_bit_q == 5'(W - 1);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sh_q <= SAR_SH_IDLE;
			sh_cnt_q <= 5'h00;
			sh_bit_q <= 5'h00;
		end else begin
			sh_cnt_q <= sh_cnt_q + 5'h01;
			case (sh_q)
				SAR_SH_IDLE: begin
					sh_cnt_q <= 5'h00;
					if (int_go) begin
						sh_q <= SAR_SH_DELAY;
					end
				end
				SAR_SH_DELAY: begin
					if (dly_end) begin
						sh_q <= SAR_SH_LOW;
						sh_cnt_q <= 5'h00;
						sh_bit_q <= 5'h00;
					end
				end
				SAR_SH_LOW: begin
					if (half_end) begin
						sh_q <= SAR_SH_HIGH;
						sh_cnt_q <= 5'h00;
					end
				end
				SAR_SH_HIGH: begin
					if (half_end) begin
						sh_cnt_q <= 5'h00;
						sh_bit_q <= sh_bit_q + 5'h01;
						sh_q <= last_bit ? SAR_SH_IDLE : SAR_SH_LOW;
					end
				end
				default: begin
					sh_q <= SAR_SH_IDLE;
				end
			endcase
		end
	end

	// The clock pin is only driven in internal mode; low between bursts.
	assign link.sclk_dev_o = sh_q == SAR_SH_HIGH;
	assign link.sclk_dev_oe = ~ext_s;

	// Named moments at which the serial data path acts.
	wire int_bit = (sh_q == SAR_SH_DELAY && dly_end) ||
		(sh_q == SAR_SH_HIGH && half_end && !last_bit);
	wire int_done = sh_q == SAR_SH_HIGH && half_end && last_bit;

	// Output shift register. In external mode each falling edge moves
	// the next bit out and takes the cascade level in at the bottom,
	// so the seventeenth fall shows the first cascaded bit.
	logic [W-1:0] shreg_q;
	logic sdo_q;
	logic tag_hold_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			shreg_q <= 16'h0000;
			sdo_q <= 1'b0;
			tag_hold_q <= 1'b0;
		end else if (int_go) begin
			shreg_q <= res_q;
			tag_hold_q <= tag_s;
		end else if (int_bit) begin
			sdo_q <= shreg_q[W-1];
			shreg_q <= {shreg_q[W-2:0], tag_hold_q};
		end else if (int_done) begin
			sdo_q <= tag_hold_q;
		end else if (commit) begin
			shreg_q <= conv_val_q;
		end else if (ext_fall) begin
			sdo_q <= shreg_q[W-1];
			shreg_q <= {shreg_q[W-2:0], tag_s};
		end else if (win_open) begin
			tag_hold_q <= tag_s;
		end else if (win_close) begin
			sdo_q <= tag_hold_q;
		end
	end

	// The serial output is never released; it feeds the next stage.
	assign link.sdo = sdo_q;
endmodule
`default_nettype wire

// >>> logic/sar_host.sv
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// Pointer wrap relies on a power-of-two depth.
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk_depth
		$error("sar_fifo: DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	// Extra pointer bit tells full from empty.
	wire empty = wr_q == rd_q;
	wire full = wr_q == {~rd_q[AW], rd_q[AW-1:0]};
	wire push = in_valid & ~full;
	wire pop = out_ready & ~empty;
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem[rd_q[AW-1:0]];
	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
		end
	end
endmodule

module sar_host #(
	parameter int WORDS = 1,
	parameter bit EXT_CLK = 1'b1,
	parameter int HALF = 4,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Link to the converter chain
	sar_link_if.host link,
	// Conversion request
	input wire logic start,
	output logic start_ready,
	// Result words
	output logic word_valid,
	input wire logic word_ready,
	output logic [sar_pkg::RES_BITS-1:0] word_data
);
	localparam int W = sar_pkg::RES_BITS;
	localparam int FALLS = WORDS * sar_pkg::WORD_SLOT - 1;
	// The phase counter is four bits wide and the low phase is HALF+2.
	if (WORDS > 1 && !EXT_CLK) begin : g_chk_clk
		$error("sar_host: cascades need the external clock");
	end
	if (HALF < 4 || HALF > 14 ||
		2 * HALF * sar_pkg::CLK_NS < sar_pkg::EXT_PER_MIN_NS)
	begin : g_chk_half
		$error("sar_host: HALF out of range");
	end
	if (WORDS < 1 || FALLS > 1023) begin : g_chk_words
		$error("sar_host: WORDS out of range");
	end

	typedef enum logic [2:0] {
		SAR_H_IDLE = 3'b000,
		SAR_H_CONV = 3'b001,
		SAR_H_WAIT = 3'b010,
		SAR_H_READ = 3'b011,
		SAR_H_INT = 3'b100
	} sar_h_t;

	// Converter pins pass two flops before use.
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 3'h2;
			sync2_q <= 3'h2;
		end else begin
			sync1_q <= {link.sdo, link.busy_n, link.sclk};
			sync2_q <= sync1_q;
		end
	end
	wire sdo_s = sync2_q[2];
	wire busy_n_s = sync2_q[1];
	wire sclk_s = sync2_q[0];

	sar_h_t st_q;
	logic [3:0] ph_q;
	logic [9:0] fall_q;
	logic [4:0] slot_q;
	logic [W-1:0] word_q;
	logic seen_low_q;
	logic sclk_q;
	logic sclk_prev_q;
	logic fifo_ready;

	// Decode of the read timing; low phase is two cycles longer than
	// high so that the round trip through both synchronisers settles.
	wire ph_hi_end = sclk_q && ph_q == 4'(HALF - 1);
	wire ph_lo_end = !sclk_q && ph_q == 4'(HALF + 1);
	wire data_bit = slot_q < 5'(W);
	wire word_end = slot_q == 5'(W - 1);
	wire int_rise = sclk_s & ~sclk_prev_q;
	wire push = (st_q == SAR_H_READ && ph_lo_end && word_end) ||
		(st_q == SAR_H_INT && int_rise && word_end);
	wire stall = push & ~fifo_ready;
	wire go = start & fifo_ready && st_q == SAR_H_IDLE;
	wire [W-1:0] word_next = {word_q[W-2:0], sdo_s};
	assign start_ready = st_q == SAR_H_IDLE && fifo_ready;

	// Sequencer: convert pulse, then read either after busy rises
	// (external clock) or alongside the internal clock burst.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= SAR_H_IDLE;
			ph_q <= 4'h0;
			fall_q <= 10'h000;
			slot_q <= 5'h00;
			word_q <= 16'h0000;
			seen_low_q <= 1'b0;
			sclk_q <= 1'b0;
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			ph_q <= ph_q + 4'h1;
			case (st_q)
				SAR_H_IDLE: begin
					ph_q <= 4'h0;
					seen_low_q <= 1'b0;
					slot_q <= 5'h00;
					fall_q <= 10'h000;
					if (go) begin
						st_q <= SAR_H_CONV;
					end
				end
				SAR_H_CONV: begin
					if (ph_q == 4'(sar_pkg::CONV_PULSE_CYC - 1)) begin
						st_q <= EXT_CLK ? SAR_H_WAIT : SAR_H_INT;
					end
				end
				SAR_H_WAIT: begin
					ph_q <= 4'h0;
					if (!busy_n_s) begin
						seen_low_q <= 1'b1;
					end
					if (seen_low_q && busy_n_s) begin
						st_q <= SAR_H_READ;
						sclk_q <= 1'b1;
					end
				end
				SAR_H_READ: begin
					if (stall) begin
						ph_q <= ph_q; // Hold the clock low until room.
					end else if (ph_hi_end) begin
						sclk_q <= 1'b0;
						ph_q <= 4'h0;
						fall_q <= fall_q + 10'h001;
					end else if (ph_lo_end) begin
						ph_q <= 4'h0;
						if (data_bit)
							word_q <= word_next;
						slot_q <= word_end || slot_q < 5'(W - 1) ?
							slot_q + 5'h01 : 5'h00;
						if (fall_q == 10'(FALLS)) begin
							st_q <= SAR_H_IDLE;
						end else begin
							sclk_q <= 1'b1;
						end
					end
				end
				SAR_H_INT: begin
					if (int_rise && data_bit) begin
						word_q <= word_next;
						slot_q <= slot_q + 5'h01;
					end
					if (!data_bit && busy_n_s) begin
						st_q <= SAR_H_IDLE;
					end
				end
				default: begin
					st_q <= SAR_H_IDLE;
				end
			endcase
		end
	end

	// The host drives the clock pin only when it owns the clock.
	assign link.sclk_host_o = sclk_q;
	assign link.sclk_host_oe = EXT_CLK;
	assign link.rc_n = st_q != SAR_H_CONV;
	assign link.cs_n = !(st_q == SAR_H_CONV ||
		(EXT_CLK && st_q != SAR_H_IDLE));

	sar_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(word_next),
		.out_valid(word_valid),
		.out_ready(word_ready),
		.out_data(word_data)
	);
endmodule
`default_nettype wire

// >>> verif/sar_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sar_link_sva (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Link wires
	input wire logic rc_n,
	input wire logic cs_n,
	input wire logic busy_n,
	input wire logic sdo,
	input wire logic sclk,
	input wire logic sclk_host_oe,
	input wire logic sclk_dev_oe
);
	localparam int BUSY_LOW = sar_pkg::BUSY_CYC;
	localparam int BUSY_LIM = sar_pkg::BUSY_MAX_CYC;
	logic [9:0] busy_cnt_q;
	logic [9:0] busy_cnt_d;

	// Busy low counter; it saturates so a stuck busy cannot wrap back.
	assign busy_cnt_d = busy_n ? 10'h000 :
		((busy_cnt_q == 10'h3FF) ? busy_cnt_q : busy_cnt_q + 10'h001);

	// Counter register.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy_cnt_q <= 10'h000;
		end else begin
			busy_cnt_q <= busy_cnt_d;
		end
	end

	// Everything here lives in the one system clock domain.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	AST_BUSY_LEN: assert property (
		$rose(busy_n) |-> busy_cnt_q == BUSY_LOW)
		else $error("busy low time is not 18 us");
	AST_BUSY_MAX: assert property (
		busy_cnt_q <= BUSY_LIM)
		else $error("busy stayed low beyond 20 us");
	AST_BUSY_ANSWER: assert property (
		$fell(rc_n) && busy_n |-> ##[1:6] !busy_n)
		else $error("busy did not fall after a convert request");
	AST_START_PAIR: assert property (
		$fell(rc_n) |-> !cs_n ##1 rc_n)
		else $error("convert request without select or too long");
	AST_NO_CLK_BUSY: assert property (
		!busy_n |-> !sclk)
		else $error("shift clock active during conversion");
	AST_EXT_HIGH: assert property (
		$rose(sclk) |-> sclk[*3])
		else $error("shift clock high phase too short");
	AST_EXT_LOW: assert property (
		$fell(sclk) |-> !sclk[*3])
		else $error("shift clock low phase too short");
	AST_SDO_HOLD: assert property (
		!cs_n && sclk && $past(sclk) |-> $stable(sdo))
		else $error("serial output moved while shift clock high");
	AST_EXT_ONLY: assert property (
		sclk_host_oe |-> !sclk_dev_oe)
		else $error("both ends drive the shift clock");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk, rstn, start, word_ready, ext_clk_sel, cascade_in;
	logic signed [17:0] sample_in;
	logic start_ready, word_valid;
	logic [15:0] word_data, wbits, exp_w;
	int n_errors, cmp_count, cyc, nfall;
	logic [15:0] exp_q[$];
	logic [15:0] last_res;
	logic conv_busy;
	// Internal clock pair: its own request, words and model queue.
	logic start_i, start_ready_i, word_valid_i;
	logic [15:0] word_data_i, wbits_i, prev_i, exp_wi;
	logic [15:0] exp_qi[$];
	int nrise_i;
	realtime t_rise, per_min, per_max;

	sar_link_if link();
	sar_link_if link_i();

	sar_dev sar_dev_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.sample_in(sample_in), .ext_clk_sel(ext_clk_sel),
		.cascade_in(cascade_in), .last_result(last_res),
		.conv_busy(conv_busy));

	sar_host #(.WORDS(1), .EXT_CLK(1'b1), .HALF(4), .FIFO_DEPTH(16))
		sar_host_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.start(start), .start_ready(start_ready), .word_valid(word_valid),
		.word_ready(word_ready), .word_data(word_data));

	// Second pair in internal clock mode; its strap is tied low on purpose.
	if (1) begin : g_int
		sar_dev sar_dev_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link_i),
			.sample_in(sample_in), .ext_clk_sel(1'b0),
			.cascade_in(cascade_in), .last_result(), .conv_busy());
		sar_host #(.WORDS(1), .EXT_CLK(1'b0), .HALF(4), .FIFO_DEPTH(16))
			sar_host_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link_i),
			.start(start_i), .start_ready(start_ready_i),
			.word_valid(word_valid_i), .word_ready(word_ready),
			.word_data(word_data_i));
	end

	sar_link_sva sar_link_sva_inst (.sys_clk(sys_clk), .rstn(rstn),
		.rc_n(link.rc_n), .cs_n(link.cs_n), .busy_n(link.busy_n),
		.sdo(link.sdo), .sclk(link.sclk), .sclk_host_oe(link.sclk_host_oe),
		.sclk_dev_oe(link.sclk_dev_oe));

	// Free running system clock.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Reference clamp: out of range codes pin to full scale, never wrap.
	function automatic logic [15:0] clamp(input int v);
		if (v > 32767) return 16'h7FFF;
		if (v < -32768) return 16'h8000;
		return v[15:0];
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Bounded wait for the select line to reach a level.
	task automatic wait_cs(input logic lvl);
		int i;
		for (i = 0; i < 2000 && link.cs_n !== lvl; i++) begin
			@(posedge sys_clk);
			#1;
		end
		check(16'(link.cs_n), 16'(lvl));
	endtask

	// One conversion and readout; the cascade level is held all along
	// because the device catches it when the read window opens and again at every falling edge.
	task automatic convert(input int v);
		int i;
		logic tag;
		tag = 1'($urandom);
		for (i = 0; i < 900 && start_ready !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		sample_in = v[17:0];
		cascade_in = tag;
		nfall = 0;
		start = 1'b1;
		exp_q.push_back(clamp(v));
		@(posedge sys_clk);
		#1;
		start = 1'b0;
		wait_cs(1'b0);
		repeat (10) @(posedge sys_clk);
		#1;
		check(16'(conv_busy), 16'h0001);
		wait_cs(1'b1);
		check(16'(conv_busy), 16'h0000);
		check(last_res, clamp(v));
		repeat (6) @(posedge sys_clk);
		#1;
		check(16'(link.sdo), 16'(tag));
		check(wbits, clamp(v));
		check(16'(nfall), 16'h0010);
	endtask

	// Wire monitor: a bit settles after each falling shift clock edge.
	initial begin
		forever begin
			@(negedge link.sclk);
			if (link.cs_n === 1'b0) begin
				repeat (5) @(negedge sys_clk);
				wbits = {wbits[14:0], link.sdo};
				nfall++;
			end
		end
	end

	// Every word leaving the buffer is compared against the model queue.
	always @(posedge sys_clk) begin
		if (rstn && word_valid === 1'b1 && word_ready === 1'b1) begin
			exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : ~word_data;
			check(word_data, exp_w);
		end
	end

	// One internal clock conversion; its burst carries the previous word,
	// so the model keeps the last clamped code in prev_i.
	task automatic convert_int(input int v);
		int i;
		logic tag;
		tag = 1'($urandom);
		for (i = 0; i < 900 && start_ready_i !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		sample_in = v[17:0];
		cascade_in = tag;
		nrise_i = 0;
		per_min = 1.0e9;
		per_max = 0.0;
		start_i = 1'b1;
		exp_qi.push_back(prev_i);
		@(posedge sys_clk);
		#1;
		start_i = 1'b0;
		repeat (470) @(posedge sys_clk);
		#1;
		check(16'(link_i.sdo), 16'(tag));
		check(wbits_i, prev_i);
		check(16'(nrise_i), 16'h0010);
		check(16'(per_min >= 600.0 && per_max <= 850.0), 16'h0001);
		prev_i = clamp(v);
	endtask

	// Internal clock monitor: bits are stable at each rising edge.
	always @(posedge link_i.sclk) begin
		if (nrise_i > 0 && $realtime - t_rise < per_min)
			per_min = $realtime - t_rise;
		if (nrise_i > 0 && $realtime - t_rise > per_max)
			per_max = $realtime - t_rise;
		t_rise = $realtime;
		wbits_i = {wbits_i[14:0], link_i.sdo};
		nrise_i++;
	end

	// Words from the internal clock pair against their own queue.
	always @(posedge sys_clk) begin
		if (rstn && word_valid_i === 1'b1 && word_ready === 1'b1) begin
			exp_wi = (exp_qi.size() > 0) ? exp_qi.pop_front() :
				~word_data_i;
			check(word_data_i, exp_wi);
		end
	end

	// Hang guard.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			$display("CHECK FAILED at %0t: run timed out", $time);
			end_sim();
		end
	end

	initial begin
		int i;
		int v;
		int samples[8];
		rstn = 1'b0;
		start = 1'b0;
		word_ready = 1'b0;
		ext_clk_sel = 1'b1;
		cascade_in = 1'b0;
		sample_in = 18'h00000;
		wbits = 16'h0000;
		start_i = 1'b0;
		prev_i = 16'h0000;
		wbits_i = 16'h0000;
		samples = '{131071, 32767, 32768, -32768, -32769, -131072, 0, -1};
		v = $urandom(91);
		repeat (3) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		// Fill the buffer with clamp boundaries, then random codes.
		for (i = 0; i < 16; i++) begin
			v = (i < 8) ? samples[i] : $urandom_range(262143) - 131072;
			convert(v);
		end
		// A full buffer must refuse a further conversion.
		repeat (4) @(posedge sys_clk);
		#1;
		check(16'(start_ready), 16'h0000);
		start = 1'b1;
		@(posedge sys_clk);
		#1;
		start = 1'b0;
		// Drain with random stalls on the reading side.
		repeat (800) begin
			@(posedge sys_clk);
			#1;
			word_ready = 1'($urandom);
		end
		check(16'(exp_q.size()), 16'h0000);
		// Internal clock mode; words leave the buffer as they arrive.
		word_ready = 1'b1;
		for (i = 0; i < 4; i++) begin
			convert_int($urandom_range(262143) - 131072);
		end
		repeat (4) @(posedge sys_clk);
		#1;
		check(16'(exp_qi.size()), 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire
